// ==== rtl/rsalu_top.sv ====
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - rotate right into working, flags untouched
// - memory rotate through borrow bit
// - borrow rotate, result into working
// - working minus memory minus inverted borrow
// - subtract to working, four flags updated
// - subtract to memory, same flags
// - borrow clear on negative, else set
// - decrement memory, skip when zero
// - skip adds one dummy cycle
// - nonzero result continues without skip
`include "rsalu_regs.svh"
module rsalu_top (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_op_valid,
  input wire rsalu_pkg::rsalu_op_t i_op_code,
  input wire rsalu_pkg::rsalu_byte_t i_mem_data,
  input wire rsalu_pkg::rsalu_addr_t i_reg_addr,
  input wire rsalu_pkg::rsalu_byte_t i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output rsalu_pkg::rsalu_byte_t o_reg_rdata,
  output rsalu_pkg::rsalu_byte_t o_working,
  output rsalu_pkg::rsalu_flags_t o_flags,
  output logic o_mem_wr,
  output rsalu_pkg::rsalu_byte_t o_mem_wdata,
  output logic o_skip,
  output logic o_busy
);
  import rsalu_pkg::*;

  rsalu_state_t state;
  rsalu_state_t next_state;
  rsalu_byte_t next_working;
  rsalu_flags_t next_flags;
  rsalu_byte_t next_mem_wdata;
  logic next_mem_wr;
  logic next_skip;
  logic take;
  logic through;
  rsalu_byte_t rot_result;
  logic rot_borrow;
  rsalu_byte_t sub_diff;
  logic sub_borrow;
  logic sub_nibble;
  logic sub_range;
  logic sub_null;
  rsalu_byte_t dec_value;

  // address match, used by both register write paths
  function automatic logic reg_hit(input rsalu_addr_t addr, input rsalu_addr_t offset);
    return addr == offset;
  endfunction : reg_hit

  // an op is only taken outside the dummy cycle; ops offered then are dropped
  assign take = i_clk_en && i_op_valid && (state == st_run);
  assign through = (i_op_code != op_rotate_right_to_working);
  assign dec_value = i_mem_data - `RSALU_DEC_STEP;

  rsalu_rotate u_rotate (
    .i_data(i_mem_data),
    .i_borrow(o_flags[`RSALU_FLAG_BORROW]),
    .i_through(through),
    .o_result(rot_result),
    .o_borrow(rot_borrow)
  );

  rsalu_subtract u_subtract (
    .i_minuend(o_working),
    .i_subtrahend(i_mem_data),
    .i_borrow_in(o_flags[`RSALU_FLAG_BORROW]),
    .o_diff(sub_diff),
    .o_borrow_out(sub_borrow),
    .o_nibble(sub_nibble),
    .o_range(sub_range),
    .o_null(sub_null)
  );

  // next values; an op that writes a register wins over a bus write beside it
  always_comb begin
    next_working = o_working;
    next_flags = o_flags;
    next_mem_wr = 1'b0;
    next_mem_wdata = o_mem_wdata;
    next_skip = 1'b0;
    if (i_reg_wr && reg_hit(i_reg_addr, `RSALU_ADDR_WORKING)) begin
      next_working = i_reg_wdata;
    end
    if (i_reg_wr && reg_hit(i_reg_addr, `RSALU_ADDR_STATUS)) begin
      next_flags = i_reg_wdata[3:0];
    end
    if (take) begin
      case (i_op_code)
        op_rotate_right_to_working: begin
          next_working = rot_result;
        end
        op_rotate_right_through_borrow_mem: begin
          next_mem_wr = 1'b1;
          next_mem_wdata = rot_result;
          next_flags[`RSALU_FLAG_BORROW] = rot_borrow;
        end
        op_rotate_right_through_borrow_working: begin
          next_working = rot_result;
          next_flags[`RSALU_FLAG_BORROW] = rot_borrow;
        end
        op_subtract_with_borrow_working: begin
          next_working = sub_diff;
          next_flags = {sub_range, sub_null, sub_nibble, sub_borrow};
        end
        op_subtract_with_borrow_memory: begin
          next_mem_wr = 1'b1;
          next_mem_wdata = sub_diff;
          next_flags = {sub_range, sub_null, sub_nibble, sub_borrow};
        end
        op_decrement_skip_if_null: begin
          next_mem_wr = 1'b1;
          next_mem_wdata = dec_value;
          next_skip = rsalu_is_null(dec_value);
        end
        default: begin
          next_working = next_working;
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (next_skip) begin
          next_state = st_dummy;
        end
      end
      st_dummy: begin
        next_state = st_run;
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  // sequencing state and the busy output mirror each other
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= st_run;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      o_busy <= (next_state == st_dummy);
    end
  end

  // working register and status flags
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_working <= `RSALU_RST_WORKING;
      o_flags <= `RSALU_RST_FLAGS;
    end else if (i_clk_en) begin
      o_working <= next_working;
      o_flags <= next_flags;
    end
  end

  // memory write and skip strobes, one cycle each
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_wr <= 1'b0;
      o_mem_wdata <= `RSALU_RST_WORKING;
      o_skip <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_wr <= next_mem_wr;
      o_mem_wdata <= next_mem_wdata;
      o_skip <= next_skip;
    end
  end

  // read data show the value before any update of the same cycle
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= `RSALU_READ_IDLE;
    end else if (i_clk_en) begin
      o_reg_rdata <= `RSALU_READ_IDLE;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `RSALU_ADDR_WORKING: o_reg_rdata <= o_working;
          `RSALU_ADDR_STATUS: o_reg_rdata <= {4'h0, o_flags};
          default: o_reg_rdata <= `RSALU_READ_IDLE;
        endcase
      end
    end
  end

  // reference values for the checks, built apart from the datapath
  rsalu_byte_t ref_diff;
  logic ref_nonneg;
  logic [8:0] ref_need;
  assign ref_diff = o_working - i_mem_data - {7'h00, ~o_flags[`RSALU_FLAG_BORROW]};
  assign ref_need = {1'b0, i_mem_data} + {8'h00, ~o_flags[`RSALU_FLAG_BORROW]};
  assign ref_nonneg = ({1'b0, o_working} >= ref_need);

  sequence s_take(rsalu_op_t op);
    i_clk_en && i_op_valid && !o_busy && !i_reg_wr && (i_op_code == op);
  endsequence

  sequence s_skip_take;
    s_take(op_decrement_skip_if_null) and (i_mem_data == `RSALU_DEC_LAST);
  endsequence

  sequence s_subtract;
    s_take(op_subtract_with_borrow_working) or s_take(op_subtract_with_borrow_memory);
  endsequence

  chk_rot_working: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_rotate_right_to_working) |=>
      (o_working == {$past(i_mem_data[0]), $past(i_mem_data[7:1])})
      && (o_flags == $past(o_flags)) && !o_mem_wr)
    else $error("rotate to working wrong");

  chk_rot_mem_borrow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_rotate_right_through_borrow_mem) |=>
      o_mem_wr && (o_mem_wdata == {$past(o_flags[`RSALU_FLAG_BORROW]), $past(i_mem_data[7:1])})
      && (o_flags[`RSALU_FLAG_BORROW] == $past(i_mem_data[0]))
      && (o_working == $past(o_working)))
    else $error("rotate through borrow to memory wrong");

  chk_rot_work_borrow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_rotate_right_through_borrow_working) |=>
      !o_mem_wr && (o_working == {$past(o_flags[`RSALU_FLAG_BORROW]), $past(i_mem_data[7:1])})
      && (o_flags[`RSALU_FLAG_BORROW] == $past(i_mem_data[0])))
    else $error("rotate through borrow to working wrong");

  chk_sub_working: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_subtract_with_borrow_working) |=>
      (o_working == $past(ref_diff)) && !o_mem_wr
      && (o_flags[`RSALU_FLAG_NULL] == ($past(ref_diff) == 8'h00)))
    else $error("subtract to working wrong");

  chk_sub_memory: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_subtract_with_borrow_memory) |=>
      o_mem_wr && (o_mem_wdata == $past(ref_diff)) && (o_working == $past(o_working)))
    else $error("subtract to memory wrong");

  chk_sub_borrow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_subtract |=> (o_flags[`RSALU_FLAG_BORROW] == $past(ref_nonneg)))
    else $error("borrow flag after subtract wrong");

  chk_dec_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_decrement_skip_if_null) |=>
      o_mem_wr && (o_mem_wdata == $past(i_mem_data) - `RSALU_DEC_STEP)
      && (o_skip == ($past(i_mem_data) == `RSALU_DEC_LAST)))
    else $error("decrement write or skip wrong");

  chk_dec_dummy: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_skip_take ##1 i_clk_en |-> o_busy && o_skip ##1 !o_busy && !o_skip)
    else $error("skip dummy cycle wrong");

  chk_dec_continue: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_decrement_skip_if_null) and (i_mem_data != `RSALU_DEC_LAST) |=>
      !o_skip && !o_busy)
    else $error("nonzero decrement skipped");

  chk_dec_flags: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_take(op_decrement_skip_if_null) |=> (o_flags == $past(o_flags)))
    else $error("decrement changed flags");

  chk_dummy_refuse: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_busy && i_clk_en && !i_reg_wr |=> !o_mem_wr && $stable(o_working) && $stable(o_flags))
    else $error("op taken during dummy cycle");

  // skip strobe and dummy cycle travel together
  chk_skip_busy: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_skip |-> o_busy)
    else $error("skip strobe without dummy cycle");

  // dummy cycle lasts one enabled cycle only
  chk_dummy_once: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_busy && i_clk_en |=> !o_busy)
    else $error("dummy cycle longer than one cycle");
endmodule : rsalu_top
`default_nettype wire

// ==== rtl/rsalu_regs.svh ====
`ifndef RSALU_REGS_SVH
`define RSALU_REGS_SVH
// register offsets on the plain port
`define RSALU_ADDR_WORKING 4'h0
`define RSALU_ADDR_STATUS 4'h4
// status field positions
`define RSALU_FLAG_BORROW 0
`define RSALU_FLAG_NIBBLE 1
`define RSALU_FLAG_NULL 2
`define RSALU_FLAG_RANGE 3
// reset values
`define RSALU_RST_WORKING 8'h00
`define RSALU_RST_FLAGS 4'h0
`define RSALU_READ_IDLE 8'h00
// decrement step and the value that decrements to zero
`define RSALU_DEC_STEP 8'h01
`define RSALU_DEC_LAST 8'h01
`endif

// ==== rtl/rsalu_pkg.sv ====
`default_nettype none
package rsalu_pkg;
  typedef logic [7:0] rsalu_byte_t;
  typedef logic [3:0] rsalu_flags_t;
  typedef logic [3:0] rsalu_addr_t;
  typedef enum logic [2:0] {
    op_idle,
    op_rotate_right_to_working,
    op_rotate_right_through_borrow_mem,
    op_rotate_right_through_borrow_working,
    op_subtract_with_borrow_working,
    op_subtract_with_borrow_memory,
    op_decrement_skip_if_null
  } rsalu_op_t;
  typedef enum logic {st_run, st_dummy} rsalu_state_t;
  // zero test shared by subtract and decrement
  function automatic logic rsalu_is_null(input rsalu_byte_t v);
    return v == 8'h00;
  endfunction : rsalu_is_null
endpackage : rsalu_pkg
`default_nettype wire

// ==== rtl/rsalu_rotate.sv ====
`timescale 1ns/1ns
`default_nettype none
module rsalu_rotate (
  input wire rsalu_pkg::rsalu_byte_t i_data,
  input wire logic i_borrow,
  input wire logic i_through,
  output wire rsalu_pkg::rsalu_byte_t o_result,
  output wire logic o_borrow
);
  import rsalu_pkg::*;
  genvar g;
  // bits 0 to 6 take the bit above them
  generate
    for (g = 0; g < 7; g++) begin : g_shift
      assign o_result[g] = i_data[g + 1];
    end
  endgenerate
  assign o_result[7] = i_through ? i_borrow : i_data[0];
  assign o_borrow = i_data[0];
endmodule : rsalu_rotate
`default_nettype wire

// ==== rtl/rsalu_subtract.sv ====
`timescale 1ns/1ns
`default_nettype none
module rsalu_subtract (
  input wire rsalu_pkg::rsalu_byte_t i_minuend,
  input wire rsalu_pkg::rsalu_byte_t i_subtrahend,
  input wire logic i_borrow_in,
  output wire rsalu_pkg::rsalu_byte_t o_diff,
  output wire logic o_borrow_out,
  output wire logic o_nibble,
  output wire logic o_range,
  output wire logic o_null
);
  import rsalu_pkg::*;
  logic take_one;
  logic [8:0] full;
  logic [4:0] low;
  assign take_one = ~i_borrow_in;
  assign full = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {8'h00, take_one};
  // low nibble done apart so the nibble borrow needs no extra carry tap
  assign low = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]} - {4'h0, take_one};
  assign o_diff = full[7:0];
  assign o_borrow_out = ~full[8];
  assign o_nibble = ~low[4];
  // signed overflow: operands differ in sign and result sign left the minuend's
  assign o_range = (i_minuend[7] ^ i_subtrahend[7]) & (i_minuend[7] ^ full[7]);
  assign o_null = rsalu_is_null(full[7:0]);
endmodule : rsalu_subtract
`default_nettype wire

// ==== test/rsalu_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// data memory beside the datapath: serves the addressed byte, takes write-backs
module rsalu_mem_model (
  input wire logic i_clock,
  input wire logic i_take,
  input wire logic [3:0] i_addr,
  input wire logic i_mem_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [16];
  logic [3:0] addr_q;
  // the write-back comes a cycle after the request, so its address is held here
  always @(posedge i_clock) begin
    if (i_take)
      addr_q <= i_addr;
    if (i_mem_wr)
      mem[addr_q] <= i_wdata;
  end
  // forward a pending write so back-to-back ops on one byte see fresh data
  assign o_rdata = (i_mem_wr && i_addr == addr_q) ? i_wdata : mem[i_addr];
endmodule : rsalu_mem_model
`default_nettype wire

// ==== test/rotate_subtract_skip_alu_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rsalu_regs.svh"
module rotate_subtract_skip_alu_bench;
  import rsalu_pkg::*;
  logic i_clock = 0, i_sys_rst = 1, i_clk_en = 1, i_op_valid = 0, i_reg_wr = 0, i_reg_rd = 0;
  rsalu_op_t i_op_code = op_idle;
  rsalu_addr_t i_reg_addr = 4'h0, mem_addr = 4'h0;
  rsalu_byte_t i_reg_wdata = 8'h00, mem_data, o_reg_rdata, o_working, o_mem_wdata;
  rsalu_flags_t o_flags;
  logic o_mem_wr, o_skip, o_busy;
  rsalu_byte_t ew = 8'h00, ewd = 8'h00;
  rsalu_byte_t em [16];
  rsalu_flags_t ef = 4'h0;
  int miscompares = 0, total_checks = 0;
  always #20 i_clock = ~i_clock;
  rsalu_top dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_mem_data(mem_data),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_working(o_working),
    .o_flags(o_flags), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .o_skip(o_skip), .o_busy(o_busy));
  rsalu_mem_model mem_u (.i_clock(i_clock), .i_take(i_op_valid & i_clk_en & !o_busy),
    .i_addr(mem_addr), .i_mem_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(mem_data));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // difference and flags a subtract should leave: {range, null, nibble, borrow, diff}
  function automatic logic [11:0] exp_sub(input rsalu_byte_t w, input rsalu_byte_t m,
                                          input logic c);
    logic [8:0] d;
    logic [4:0] lo;
    d = {1'b0, w} - {1'b0, m} - 9'(!c);
    lo = {1'b0, w[3:0]} - {1'b0, m[3:0]} - 5'(!c);
    return {(w[7] != m[7]) && (d[7] != w[7]), d[7:0] == 8'h00, !lo[4], !d[8], d[7:0]};
  endfunction : exp_sub
  task automatic reg_wr(input rsalu_addr_t a, input rsalu_byte_t d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    #1;
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input rsalu_addr_t a, input rsalu_byte_t exp);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    #1;
    i_reg_rd <= 1'b0;
    check(o_reg_rdata, exp);
    @(posedge i_clock);
    #1;
    check(o_reg_rdata, 8'h00);
  endtask : reg_rd
  // one request; valid stays up so ops may follow back to back
  task automatic do_op(input rsalu_op_t op, input rsalu_addr_t a);
    rsalu_byte_t m;
    logic [11:0] s;
    logic wr, sk;
    m = em[a];
    s = exp_sub(ew, m, ef[0]);
    wr = 1'b0;
    sk = 1'b0;
    case (op)
      op_rotate_right_to_working: ew = {m[0], m[7:1]};
      op_rotate_right_through_borrow_mem: begin
        wr = 1'b1;
        ewd = {ef[0], m[7:1]};
        ef[0] = m[0];
      end
      op_rotate_right_through_borrow_working: begin
        ew = {ef[0], m[7:1]};
        ef[0] = m[0];
      end
      op_subtract_with_borrow_working: begin
        ew = s[7:0];
        ef = s[11:8];
      end
      op_subtract_with_borrow_memory: begin
        wr = 1'b1;
        ewd = s[7:0];
        ef = s[11:8];
      end
      op_decrement_skip_if_null: begin
        wr = 1'b1;
        ewd = m - 8'h01;
        sk = (m == 8'h01);
      end
      default: wr = 1'b0;
    endcase
    if (wr)
      em[a] = ewd;
    i_op_valid <= 1'b1;
    i_op_code <= op;
    mem_addr <= a;
    @(posedge i_clock);
    #1;
    check(o_working, ew);
    check(o_flags, ef);
    check(o_mem_wr, wr);
    check(o_mem_wdata, ewd);
    check(o_skip, sk);
    check(o_busy, sk);
    // a request in the dummy cycle is dropped
    if (sk) begin
      i_op_code <= op_rotate_right_to_working;
      @(posedge i_clock);
      #1;
      check(o_working, ew);
      check(o_busy, 1'b0);
    end
  endtask : do_op
  task automatic idle;
    i_op_code <= op_idle;
    @(posedge i_clock);
    #1;
  endtask : idle
  initial begin
    void'($urandom(7));
    for (int k = 0; k < 16; k++) begin
      em[k] = 8'($urandom);
      mem_u.mem[k] = em[k];
    end
    repeat (10) @(posedge i_clock);
    #1;
    i_sys_rst <= 1'b0;
    check(o_working, `RSALU_RST_WORKING);
    reg_wr(`RSALU_ADDR_WORKING, 8'h5A);
    reg_rd(`RSALU_ADDR_WORKING, 8'h5A);
    reg_wr(`RSALU_ADDR_STATUS, 8'hFF);
    reg_rd(`RSALU_ADDR_STATUS, 8'h0F);
    reg_wr(4'h2, 8'h33);
    reg_rd(4'h2, 8'h00);
    ew = 8'h5A;
    ef = 4'hF;
    // zero result, then negative, then borrow-in with signed overflow
    em[1] = 8'h5A;
    em[2] = 8'h01;
    em[3] = 8'h7F;
    em[5] = 8'h02;
    for (int k = 1; k < 6; k++)
      mem_u.mem[k] = em[k];
    do_op(op_subtract_with_borrow_working, 4'h1);
    do_op(op_subtract_with_borrow_working, 4'h2);
    do_op(op_subtract_with_borrow_memory, 4'h3);
    do_op(op_rotate_right_through_borrow_mem, 4'h3);
    // 02 to 01 runs on, 01 to 00 skips, 00 wraps to FF and runs on
    repeat (3) do_op(op_decrement_skip_if_null, 4'h5);
    do_op(rsalu_op_t'(3'h7), 4'h5);
    // enable low: the offered op and every output stay frozen
    i_clk_en <= 1'b0;
    i_op_code <= op_rotate_right_to_working;
    repeat (2) @(posedge i_clock);
    #1;
    check(o_working, ew);
    check(o_flags, ef);
    check(o_mem_wdata, ewd);
    i_clk_en <= 1'b1;
    i_op_code <= op_idle;
    @(posedge i_clock);
    #1;
    // reset again mid-run; memory keeps its bytes, the datapath starts over
    i_sys_rst <= 1'b1;
    @(posedge i_clock);
    #1;
    i_sys_rst <= 1'b0;
    check(o_working, `RSALU_RST_WORKING);
    check(o_flags, `RSALU_RST_FLAGS);
    check(o_busy, 1'b0);
    ew = `RSALU_RST_WORKING;
    ef = `RSALU_RST_FLAGS;
    ewd = `RSALU_RST_WORKING;
    repeat (80) do_op(rsalu_op_t'(3'($urandom_range(7, 0))), 4'($urandom));
    idle;
    // write-backs must have landed in memory
    for (int k = 0; k < 16; k++)
      check(mem_u.mem[k], em[k]);
    end_sim;
  end
  // hang guard well beyond the roughly 115 cycles the run needs
  initial begin
    #(40 * 2000);
    miscompares++;
    end_sim;
  end
endmodule : rotate_subtract_skip_alu_bench
`default_nettype wire
